// ---- logic/asrdc_ctrl.sv ----
`timescale 1ns/1ps
// Behaviour
// RQ1: regulator control bit 7 enables the regulator when one.
// RQ2: disabled regulator asserts weak pull-low on its output pin.
// RQ3: regulator bits 1:0 pick 2.4, 2.6, 2.2 or 2.3 volts.
// RQ4: regulator bit 2 drives the bypass control.
// RQ5: unimplemented bits read zero and ignore writes.
// RQ6: reference on only when enabled and select is 00 or 01.
// RQ7: reference enable low powers down and floats the reference.
// RQ8: select 00/01 internal, 10 regulator, 11 floating dac reference.
// RQ9: reference control bit 7 reads amplifier one output, read-only.
// RQ10: eight-bit trim register drives the reference trim code.
// RQ11: dac mode 00 hi-z, 01/11 enabled, 10 grounded.
// RQ12: high register gives code 11:4, low bits 7:4 give 3:0.
// RQ13: two independent dac channels share one reference select.
// RQ14: software writes low code before high code.
// RQ15: pin switch bits 7 and 6 close dac one and two paths.
// RQ16: writes act at the completing edge; fields reset to zero.
// RQ17: converter code changes only when the high register is written.
module asrdc_ctrl
  import asrdc_pkg::*;
#(
  parameter int CODE_W = 12,
  parameter int NUM_PINS = ASRDC_NUM_PINS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic amp1_digital_output,
  output logic regulator_enable,
  output logic regulator_pull_low,
  output logic regulator_bypass,
  output logic [1:0] regulator_level_select,
  output logic reference_power_on,
  output logic reference_float,
  output asrdc_vref_t dac_reference_select,
  output logic [7:0] reference_trim,
  output logic [CODE_W-1:0] dac1_code,
  output logic [CODE_W-1:0] dac2_code,
  output logic dac1_enable,
  output logic dac1_ground,
  output logic dac2_enable,
  output logic dac2_ground,
  output logic [NUM_PINS-1:0] dac1_to_pin_switch,
  output logic [NUM_PINS-1:0] dac2_to_pin_switch
);
  logic [7:0] regulator_control_reg;
  logic [7:0] reference_control_reg;
  logic [7:0] reference_trim_reg;
  logic [7:0] analog_pin_switch_reg [NUM_PINS];
  logic [7:0] dac1_mode, dac1_low, dac1_high;
  logic [7:0] dac2_mode, dac2_low, dac2_high;
  logic [CODE_W-1:0] dac1_code_w, dac2_code_w;
  logic dac1_en_w, dac1_gnd_w, dac2_en_w, dac2_gnd_w;
  logic amp1_reg;
  logic wr_en, rd_en;
  logic [7:0] wbyte;
  // one strobe per register keeps every write address compare in one place
  logic wr_reg_ctrl, wr_ref_ctrl, wr_ref_trim;
  logic wr_dac1_mode, wr_dac1_low, wr_dac1_high;
  logic wr_dac2_mode, wr_dac2_low, wr_dac2_high;
  logic [NUM_PINS-1:0] wr_switch;
  logic [31:0] rdata_next;
  logic hit_next;

  function automatic logic is_switch(input logic [7:0] a, input int idx);
    is_switch = (a == 8'(ASRDC_OFF_SW_BASE + 8'(idx * 4)));
  endfunction

  function automatic logic [7:0] switch_mask(input int idx);
    switch_mask = (idx < ASRDC_SW_LOWER_COUNT) ? ASRDC_MASK_SW_LOWER : ASRDC_MASK_SW_UPPER;
  endfunction

  // generator runs only for an internal source code with enable set
  function automatic logic ref_on(input logic [7:0] b);
    ref_on = b[ASRDC_REF_EN_BIT] && !b[1];
  endfunction

  // zero-wait slave: setup plus one access cycle
  assign wr_en = psel && penable && pwrite && ce;
  assign rd_en = psel && !penable && !pwrite;
  assign wbyte = pwdata[7:0];
  assign wr_reg_ctrl = wr_en && (paddr == ASRDC_OFF_REG_CTRL);
  assign wr_ref_ctrl = wr_en && (paddr == ASRDC_OFF_REF_CTRL);
  assign wr_ref_trim = wr_en && (paddr == ASRDC_OFF_REF_TRIM);
  assign wr_dac1_mode = wr_en && (paddr == ASRDC_OFF_DAC1_MODE);
  assign wr_dac1_low = wr_en && (paddr == ASRDC_OFF_DAC1_LOW);
  assign wr_dac1_high = wr_en && (paddr == ASRDC_OFF_DAC1_HIGH);
  assign wr_dac2_mode = wr_en && (paddr == ASRDC_OFF_DAC2_MODE);
  assign wr_dac2_low = wr_en && (paddr == ASRDC_OFF_DAC2_LOW);
  assign wr_dac2_high = wr_en && (paddr == ASRDC_OFF_DAC2_HIGH);

  always_comb begin
    wr_switch = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      wr_switch[i] = wr_en && is_switch(paddr, i);
    end
  end

  // RQ1: regulator register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulator_control_reg <= ASRDC_RESET_VAL;
    end else if (wr_reg_ctrl) begin
      // RQ5: unimplemented bits dropped
      regulator_control_reg <= wbyte & ASRDC_MASK_REG_CTRL;
    end
  end

  // RQ9: read-only bit excluded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_control_reg <= ASRDC_RESET_VAL;
    end else if (wr_ref_ctrl) begin
      reference_control_reg <= wbyte & ASRDC_MASK_REF_CTRL;
    end
  end

  // RQ10: trim register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_trim_reg <= ASRDC_RESET_VAL;
    end else if (wr_ref_trim) begin
      reference_trim_reg <= wbyte;
    end
  end

  // RQ15: pin switch registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        analog_pin_switch_reg[i] <= ASRDC_RESET_VAL;
      end
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (wr_switch[i]) begin
          analog_pin_switch_reg[i] <= wbyte & switch_mask(i);
        end
      end
    end
  end

  // RQ9: amplifier flag sampled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp1_reg <= 1'b0;
    end else if (ce) begin
      amp1_reg <= amp1_digital_output;
    end
  end

  // RQ13: two channels
  asrdc_dac_channel #(
    .CODE_W(CODE_W)
  ) u_dac1 (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .wr_mode(wr_dac1_mode),
    // RQ14: low first assumed
    .wr_low(wr_dac1_low),
    .wr_high(wr_dac1_high),
    .wdata(wbyte),
    .mode_reg(dac1_mode),
    .low_reg(dac1_low),
    .high_reg(dac1_high),
    .code(dac1_code_w),
    .dac_enable(dac1_en_w),
    .dac_ground(dac1_gnd_w)
  );

  asrdc_dac_channel #(
    .CODE_W(CODE_W)
  ) u_dac2 (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .wr_mode(wr_dac2_mode),
    .wr_low(wr_dac2_low),
    .wr_high(wr_dac2_high),
    .wdata(wbyte),
    .mode_reg(dac2_mode),
    .low_reg(dac2_low),
    .high_reg(dac2_high),
    .code(dac2_code_w),
    .dac_enable(dac2_en_w),
    .dac_ground(dac2_gnd_w)
  );

  assign dac1_code = dac1_code_w;
  assign dac2_code = dac2_code_w;
  assign dac1_enable = dac1_en_w;
  assign dac1_ground = dac1_gnd_w;
  assign dac2_enable = dac2_en_w;
  assign dac2_ground = dac2_gnd_w;

  // RQ16: outputs follow the write edge
  // decoded from the incoming byte so controls change with the register, not a cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulator_enable <= 1'b0;
      regulator_pull_low <= 1'b1;
    end else if (wr_reg_ctrl) begin
      // RQ1: enable bit
      regulator_enable <= wbyte[ASRDC_REG_EN_BIT];
      // RQ2: pull-low while off
      regulator_pull_low <= !wbyte[ASRDC_REG_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulator_bypass <= 1'b0;
      regulator_level_select <= 2'b00;
    end else if (wr_reg_ctrl) begin
      // RQ4: bypass bit
      regulator_bypass <= wbyte[ASRDC_REG_BPS_BIT];
      // RQ3: level code passed raw
      regulator_level_select <= wbyte[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_power_on <= 1'b0;
      reference_float <= 1'b1;
    end else if (wr_ref_ctrl) begin
      // RQ6: on for enable and select 0x
      reference_power_on <= ref_on(wbyte);
      // RQ7: floats when powered down
      reference_float <= !ref_on(wbyte);
    end
  end

  // RQ8: reference source decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_reference_select <= ASRDC_VREF_INTERNAL;
    end else if (wr_ref_ctrl) begin
      case (wbyte[1:0])
        2'b00, 2'b01: dac_reference_select <= ASRDC_VREF_INTERNAL;
        2'b10: dac_reference_select <= ASRDC_VREF_REGULATOR;
        default: dac_reference_select <= ASRDC_VREF_FLOAT;
      endcase
    end
  end

  // RQ10: trim code output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_trim <= ASRDC_RESET_VAL;
    end else if (wr_ref_trim) begin
      reference_trim <= wbyte;
    end
  end

  // RQ15: switch outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac1_to_pin_switch <= '0;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (wr_switch[i]) begin
          dac1_to_pin_switch[i] <= wbyte[ASRDC_SW_DAC1_BIT];
        end
      end
    end
  end

  // both paths on one pin short it; software must keep them apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac2_to_pin_switch <= '0;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (wr_switch[i]) begin
          dac2_to_pin_switch[i] <= wbyte[ASRDC_SW_DAC2_BIT];
        end
      end
    end
  end

  // RQ5: read mux, zero upper bits
  always_comb begin
    rdata_next = '0;
    hit_next = 1'b1;
    case (paddr)
      ASRDC_OFF_REG_CTRL: rdata_next[7:0] = regulator_control_reg;
      // RQ9: registered amplifier sample
      ASRDC_OFF_REF_CTRL: rdata_next[7:0] = reference_control_reg | {amp1_reg, 7'h00};
      ASRDC_OFF_REF_TRIM: rdata_next[7:0] = reference_trim_reg;
      ASRDC_OFF_DAC1_MODE: rdata_next[7:0] = dac1_mode;
      ASRDC_OFF_DAC1_LOW: rdata_next[7:0] = dac1_low;
      ASRDC_OFF_DAC1_HIGH: rdata_next[7:0] = dac1_high;
      ASRDC_OFF_DAC2_MODE: rdata_next[7:0] = dac2_mode;
      ASRDC_OFF_DAC2_LOW: rdata_next[7:0] = dac2_low;
      ASRDC_OFF_DAC2_HIGH: rdata_next[7:0] = dac2_high;
      default: begin
        hit_next = 1'b0;
        for (int i = 0; i < NUM_PINS; i++) begin
          if (is_switch(paddr, i)) begin
            rdata_next[7:0] = analog_pin_switch_reg[i];
            hit_next = 1'b1;
          end
        end
      end
    endcase
  end

  // pready answers every setup taken with ce high; while ce is low it holds and the access phase waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= psel && !penable;
    end
  end

  // unmapped offsets answer with an error, read or write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (ce) begin
      pslverr <= psel && !penable && !hit_next;
    end
  end

  // read data captured in setup and held until the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (ce && rd_en) begin
      prdata <= rdata_next;
    end
  end

  logic unused_ok;
  assign unused_ok = ^pwdata[31:8];
endmodule

// ---- logic/asrdc_pkg.sv ----
package asrdc_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] ASRDC_OFF_REG_CTRL = 8'h00;
  localparam logic [7:0] ASRDC_OFF_REF_CTRL = 8'h04;
  localparam logic [7:0] ASRDC_OFF_REF_TRIM = 8'h08;
  localparam logic [7:0] ASRDC_OFF_DAC1_MODE = 8'h0C;
  localparam logic [7:0] ASRDC_OFF_DAC1_LOW = 8'h10;
  localparam logic [7:0] ASRDC_OFF_DAC1_HIGH = 8'h14;
  localparam logic [7:0] ASRDC_OFF_DAC2_MODE = 8'h18;
  localparam logic [7:0] ASRDC_OFF_DAC2_LOW = 8'h1C;
  localparam logic [7:0] ASRDC_OFF_DAC2_HIGH = 8'h20;
  localparam logic [7:0] ASRDC_OFF_SW_BASE = 8'h40;
  localparam int ASRDC_NUM_PINS = 8;
  // field positions
  localparam int ASRDC_REG_EN_BIT = 7;
  localparam int ASRDC_REG_BPS_BIT = 2;
  localparam int ASRDC_REF_EN_BIT = 4;
  localparam int ASRDC_AMP1_BIT = 7;
  localparam int ASRDC_SW_DAC1_BIT = 7;
  localparam int ASRDC_SW_DAC2_BIT = 6;
  // writable masks, unimplemented bits drop
  localparam logic [7:0] ASRDC_MASK_REG_CTRL = 8'h87;
  localparam logic [7:0] ASRDC_MASK_REF_CTRL = 8'h13;
  localparam logic [7:0] ASRDC_MASK_MODE = 8'h03;
  localparam logic [7:0] ASRDC_MASK_LOW = 8'hF0;
  localparam logic [7:0] ASRDC_MASK_SW_LOWER = 8'hC0;
  localparam logic [7:0] ASRDC_MASK_SW_UPPER = 8'hC0;
  localparam int ASRDC_SW_LOWER_COUNT = 5;
  localparam logic [7:0] ASRDC_RESET_VAL = 8'h00;
  // dac reference source
  typedef enum logic [1:0] {
    ASRDC_VREF_INTERNAL,
    ASRDC_VREF_REGULATOR,
    ASRDC_VREF_FLOAT
  } asrdc_vref_t;
  // dac channel state
  typedef enum logic [1:0] {
    ASRDC_DAC_HIZ,
    ASRDC_DAC_ON,
    ASRDC_DAC_GND
  } asrdc_dac_state_t;
endpackage

// ---- logic/asrdc_dac_channel.sv ----
`timescale 1ns/1ps
module asrdc_dac_channel
  import asrdc_pkg::*;
#(
  parameter int CODE_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic wr_mode,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wdata,
  output logic [7:0] mode_reg,
  output logic [7:0] low_reg,
  output logic [7:0] high_reg,
  output logic [CODE_W-1:0] code,
  output logic dac_enable,
  output logic dac_ground
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= ASRDC_RESET_VAL;
    end else if (ce && wr_mode) begin
      mode_reg <= wdata & ASRDC_MASK_MODE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_reg <= ASRDC_RESET_VAL;
      high_reg <= ASRDC_RESET_VAL;
    end else if (ce) begin
      if (wr_low) begin
        low_reg <= wdata & ASRDC_MASK_LOW;
      end
      if (wr_high) begin
        high_reg <= wdata;
      end
    end
  end

  // RQ17: atomic code load
  // low half is only latched here, so a half-written code never reaches the converter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code <= '0;
    end else if (ce && wr_high) begin
      // RQ12: high and low merge
      code <= {wdata, low_reg[7:4]};
    end
  end

  // RQ11: channel state decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_enable <= 1'b0;
      dac_ground <= 1'b0;
    end else if (ce && wr_mode) begin
      dac_enable <= wdata[0];
      dac_ground <= (wdata[1:0] == 2'b10);
    end
  end
endmodule

// ---- bench/asrdc_checker.sv ----
`timescale 1ns/1ps
module asrdc_checker
  import asrdc_pkg::*;
#(
  parameter int CODE_W = 12,
  parameter int NUM_PINS = ASRDC_NUM_PINS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic regulator_enable,
  input wire logic regulator_pull_low,
  input wire logic regulator_bypass,
  input wire logic [1:0] regulator_level_select,
  input wire logic reference_power_on,
  input wire logic reference_float,
  input wire logic [7:0] reference_trim,
  input wire logic [CODE_W-1:0] dac1_code,
  input wire logic dac1_enable,
  input wire logic dac1_ground,
  input wire logic [NUM_PINS-1:0] dac1_to_pin_switch,
  input wire logic [NUM_PINS-1:0] dac2_to_pin_switch
);
  logic wr;
  assign wr = psel && penable && pwrite && ce;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pull_low_a: assert property (regulator_pull_low != regulator_enable)
    else $error("pull-low not inverse of enable");
  ref_float_a: assert property (reference_float != reference_power_on)
    else $error("float not inverse of power");
  reg_field_a: assert property (wr && paddr == ASRDC_OFF_REG_CTRL |=>
    regulator_enable == $past(pwdata[7]) && regulator_bypass == $past(pwdata[2])
    && regulator_level_select == $past(pwdata[1:0])) else $error("regulator field");
  ref_on_a: assert property (wr && paddr == ASRDC_OFF_REF_CTRL |=>
    reference_power_on == ($past(pwdata[4]) && !$past(pwdata[1]))) else $error("ref power");
  trim_load_a: assert property (wr && paddr == ASRDC_OFF_REF_TRIM |=>
    reference_trim == $past(pwdata[7:0])) else $error("trim code");
  code_load_a: assert property (wr && paddr == ASRDC_OFF_DAC1_HIGH |=>
    dac1_code[11:4] == $past(pwdata[7:0])) else $error("code high part");
  code_hold_a: assert property (!(wr && paddr == ASRDC_OFF_DAC1_HIGH) |=>
    $stable(dac1_code)) else $error("code moved without high write");
  dac_mode_a: assert property (wr && paddr == ASRDC_OFF_DAC1_MODE |=>
    dac1_enable == $past(pwdata[0]) && dac1_ground == ($past(pwdata[1:0]) == 2'h2))
    else $error("dac mode decode");
  pin_sw_a: assert property (wr && paddr == ASRDC_OFF_SW_BASE |=>
    dac1_to_pin_switch[0] == $past(pwdata[7]) && dac2_to_pin_switch[0] == $past(pwdata[6]))
    else $error("pin switch");
  refuse_a: assert property (pready && pslverr |->
    (pwrite ? $stable(prdata) : prdata == 32'h0000_0000))
    else $error("refused read data");
  answer_a: assert property (psel && !penable && ce |=> pready)
    else $error("no answer after setup");
  cover property (wr && paddr == ASRDC_OFF_DAC1_HIGH);
  cover property (pready && pslverr);
  cover property (reference_power_on);
endmodule

bind asrdc_ctrl asrdc_checker #(.CODE_W(CODE_W), .NUM_PINS(NUM_PINS)) asrdc_checker_i (
  .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .regulator_enable, .regulator_pull_low, .regulator_bypass,
  .regulator_level_select, .reference_power_on, .reference_float, .reference_trim,
  .dac1_code, .dac1_enable, .dac1_ground, .dac1_to_pin_switch, .dac2_to_pin_switch);

// ---- bench/test_asrdc_ctrl.sv ----
`timescale 1ns/1ps
module test_asrdc_ctrl
  import asrdc_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, amp = 1'b0, pready, pslverr, r_en, r_pl, r_bp, p_on, p_fl, on;
  logic e1, g1, e2, g2;
  logic [1:0] lvl, ev;
  logic [7:0] paddr = 8'h00, trim, s1, s2, es1, es2, d, l, h, b;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [11:0] c1, c2;
  logic [11:0] ec [2];
  logic [33:0] nt;
  logic [33:0] q [$];
  logic [7:0] mk [17] = '{0:8'h87, 1:8'h13, 2:8'hFF, 3:8'h03, 4:8'hF0, 5:8'hFF, 6:8'h03,
    7:8'hF0, 8:8'hFF, default:8'hC0};
  asrdc_vref_t vsel;
  int n_fail = 0, tests_run = 0, seed = 93, i, j;
  always #5 pclk = ~pclk;
  asrdc_ctrl asrdc_ctrl_i (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .amp1_digital_output(amp), .regulator_enable(r_en),
    .regulator_pull_low(r_pl), .regulator_bypass(r_bp), .regulator_level_select(lvl),
    .reference_power_on(p_on), .reference_float(p_fl), .dac_reference_select(vsel),
    .reference_trim(trim), .dac1_code(c1), .dac2_code(c2), .dac1_enable(e1),
    .dac1_ground(g1), .dac2_enable(e2), .dac2_ground(g2), .dac1_to_pin_switch(s1),
    .dac2_to_pin_switch(s2));
  task automatic stop_test(input int extra);
    n_fail += extra;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // results are judged here as pready appears; note = {is_read, slverr, data}
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (q.size() == 0) begin
        cmp(32'h0000_0001, 32'h0000_0000);
      end else begin
        nt = q.pop_front();
        cmp(pslverr, nt[32]);
        if (nt[33]) cmp(prdata, nt[31:0]);
      end
    end
  end
  // request held until pready is seen; no release so transfers can run back to back
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      input logic [33:0] e);
    int n;
    n = 0;
    q.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) stop_test(1);
  endtask
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    apb(1'b1, a, {24'h00_0000, wd}, 34'h0_0000_0000);
    idle();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000, {2'h2, 24'h00_0000, e});
    idle();
  endtask
  function automatic logic [7:0] ad(input int k);
    return 8'(k < 9 ? 4 * k : 4 * k + 28);
  endfunction
  initial begin
    #500_000;
    stop_test(1);
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp({r_pl, p_fl, r_en, p_on}, 4'hC);
    for (i = 0; i < 17; i++) rd(ad(i), 8'h00);
    for (i = 0; i < 17; i++) begin
      wr(ad(i), 8'hFF);
      rd(ad(i), mk[i]);
    end
    ec = '{12'hFFF, 12'hFFF};
    // regulator decode, junk in unused bits
    for (i = 0; i < 8; i++) begin
      d = {i[2], 4'($random(seed)), i[0], i[1:0]};
      wr(8'h00, d);
      cmp({r_en, r_pl, r_bp, lvl}, {i[2], !i[2], i[0], i[1:0]});
    end
    for (i = 0; i < 8; i++) begin
      d = {3'($random(seed)), i[2], 2'($random(seed)), i[1:0]};
      wr(8'h04, d);
      on = i[2] && !i[1];
      ev = i[1] ? (i[0] ? 2'h2 : 2'h1) : 2'h0;
      cmp({p_on, p_fl, vsel}, {on, !on, ev});
    end
    rd(8'h04, d & 8'h13);
    amp <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(8'h04, 8'h80 | (d & 8'h13));
    d = 8'($random(seed));
    wr(8'h08, d);
    cmp(trim, d);
    // clock enable low freezes state, bus released before it returns
    ce <= 1'b0;
    psel <= 1'b1;
    pwrite <= 1'b1;
    paddr <= 8'h08;
    pwdata <= {24'h00_0000, ~d};
    @(posedge pclk);
    penable <= 1'b1;
    repeat (3) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    ce <= 1'b1;
    @(posedge pclk);
    cmp(trim, d);
    for (i = 0; i < 2; i++) begin
      b = 8'(12 * i + 12);
      for (j = 0; j < 4; j++) begin
        wr(b, {6'($random(seed)), j[1:0]});
        cmp(i ? {e2, g2} : {e1, g1}, {j[0], j == 2});
      end
      l = 8'($random(seed));
      h = 8'($random(seed));
      wr(b + 8'h04, l);
      cmp({c2, c1}, {ec[1], ec[0]});
      apb(1'b1, b + 8'h08, {24'h00_0000, h}, 34'h0_0000_0000);
      apb(1'b0, b + 8'h08, 32'h0000_0000, {2'h2, 24'h00_0000, h});
      idle();
      ec[i] = {h, l[7:4]};
      cmp({c2, c1}, {ec[1], ec[0]});
    end
    for (i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      wr(8'(64 + 4 * i), d);
      es1[i] = d[7];
      es2[i] = d[6];
    end
    cmp({s1, s2}, {es1, es2});
    apb(1'b1, 8'h30, 32'hFFFF_FFFF, 34'h1_0000_0000);
    apb(1'b0, 8'h30, 32'h0000_0000, 34'h3_0000_0000);
    idle();
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp({r_en, r_pl, p_fl, c1, s1}, {3'h3, 12'h000, 8'h00});
    stop_test(0);
  end
endmodule
